// ---- logic/probe_map.svh ----
/*
 * Address map, field layout and reset values of the probe measurement
 * register bank. Definitions only; assumes nothing of its surroundings.
 */
`ifndef PROBE_MAP_SVH
`define PROBE_MAP_SVH

// Geometry of the bank
`define PM_NUM_QTY 13
`define PM_SLOT_W 4
`define PM_ADDR_W 16
`define PM_WORD_W 16
`define PM_FLOAT_W 32
`define PM_CENTI_W 32

// Float measurement addresses (PDU address, low half at listed address)
`define PM_PEROXIDE_PPM_FLOAT 16'h0000
`define PM_RELATIVE_SATURATION_FLOAT 16'h0002
`define PM_TEMP_USED_FLOAT 16'h0004
`define PM_REL_HUMIDITY_FLOAT 16'h0006
`define PM_ABS_PEROXIDE_FLOAT 16'h0008
`define PM_DEW_POINT_FLOAT 16'h000A
`define PM_WATER_PPM_FLOAT 16'h000E
`define PM_WATER_VAPOR_PRESS_FLOAT 16'h0010
`define PM_ABS_HUMIDITY_FLOAT 16'h0012
`define PM_WATER_SAT_PRESS_FLOAT 16'h0014
`define PM_PROBE_TEMP_FLOAT 16'h0016
`define PM_PEROXIDE_VAPOR_PRESS_FLOAT 16'h0018
`define PM_MIX_SAT_PRESS_FLOAT 16'h001A
`define PM_FLOAT_LAST_ADDR 16'h001B
`define PM_FLOAT_GAP_PAIR 4'h6

// Integer copy addresses
`define PM_PEROXIDE_PPM_INT 16'h0100
`define PM_RELATIVE_SATURATION_INT 16'h0101
`define PM_TEMP_USED_INT 16'h0102
`define PM_REL_HUMIDITY_INT 16'h0103
`define PM_ABS_PEROXIDE_INT 16'h0104
`define PM_DEW_POINT_INT 16'h0105
`define PM_WATER_PPM_INT 16'h0107
`define PM_WATER_VAPOR_PRESS_INT 16'h0108
`define PM_ABS_HUMIDITY_INT 16'h0109
`define PM_WATER_SAT_PRESS_INT 16'h010A
`define PM_PROBE_TEMP_INT 16'h010B
`define PM_PEROXIDE_VAPOR_PRESS_INT 16'h010C
`define PM_MIX_SAT_PRESS_INT 16'h010D
`define PM_INT_PAGE 12'h010
`define PM_INT_LAST_LOW 4'hD
`define PM_INT_GAP_LOW 4'h6

// Register addresses of the selection sources (outside this bank)
`define PM_GIVEN_TEMP_ADDR 16'h0302
`define PM_TEMP_COMP_ADDR 16'h0505

// Quantity slots (gap removed)
`define PM_SLOT_TEMP_USED 4'h2
`define PM_SLOT_PROBE_TEMP 4'hA
`define PM_SCALED_MASK 13'h042E
`define PM_SCALE 32'h0000_0064

// Integer codes
`define PM_INT_OVER 16'h7FFF
`define PM_INT_UNAVAIL 16'h8000
`define PM_INT_UNDER 16'h8001
`define PM_CENTI_MAX 32'h0000_7FFF
`define PM_CENTI_MIN 32'hFFFF_8001

// Reset values: quiet NaN, "not available" and the zero word
`define PM_FLOAT_RESET 32'h7FC0_0000
`define PM_INT_RESET 16'h8000
`define PM_WORD_ZERO 16'h0000

`endif

// ---- logic/probe_pkg.sv ----
/*
 * Types of the probe measurement register bank.
 * Assumes probe_map.svh is on the include path.
 */
package probe_pkg;
`include "probe_map.svh"

    typedef logic [`PM_ADDR_W-1:0] pdu_addr_t;
    typedef logic [`PM_WORD_W-1:0] reg_word_t;
    typedef logic [`PM_SLOT_W-1:0] slot_t;
    typedef logic [`PM_NUM_QTY-1:0][`PM_FLOAT_W-1:0] float_bank_t;
    typedef logic [`PM_NUM_QTY-1:0][`PM_CENTI_W-1:0] centi_bank_t;
    typedef logic [`PM_NUM_QTY-1:0][`PM_WORD_W-1:0] int_bank_t;

    // Result of decoding one PDU address
    typedef struct packed {
        logic hit;
        logic is_float;
        logic high_half;
        slot_t slot;
    } addr_dec_t;

    // Answer phase of the request port
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ANSWER = 2'b10
    } phase_t;

    // Whole state of the bank
    typedef struct packed {
        float_bank_t flt;
        int_bank_t fix;
        phase_t phase;
        logic rsp_exc;
        reg_word_t rsp_data;
        logic comp_on;
    } bank_state_t;
endpackage

// ---- logic/int16_present.sv ----
/*
 * Presents one quantity, given in hundredths of its unit, as a 16-bit
 * signed register code: scaled by 100 or in base units, saturated, or
 * flagged unavailable. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
`include "probe_map.svh"
module int16_present (
    // Quantity
    input wire logic signed [31:0] centi_i,
    input wire logic avail_i,
    input wire logic scaled_i,
    // Register code
    output logic [15:0] code_o
);
    import probe_pkg::*;

    logic signed [31:0] value;

    // Pick scaling, then clamp into the reserved code points
    always_comb begin
        value = scaled_i ? centi_i : centi_i / $signed(`PM_SCALE);
        if (!avail_i) begin
            code_o = `PM_INT_UNAVAIL;
        end else if (value >= $signed(`PM_CENTI_MAX)) begin
            code_o = `PM_INT_OVER;
        end else if (value <= $signed(`PM_CENTI_MIN)) begin
            code_o = `PM_INT_UNDER;
        end else begin
            code_o = value[15:0];
        end
    end
endmodule

// ---- logic/probe_meas_regs.sv ----
/*
 * Read-only measurement register bank of the probe, seen through the
 * register-level side of the serial protocol: one register read or write
 * per request, answered one cycle later with data or an exception.
 * Assumes the protocol framer decodes frames, splits multi-register
 * reads into single requests and holds txn_hold_i for the whole frame,
 * and that the measurement process supplies values on this same clock.
 */
//
// Contract
// - The request address is the PDU address, one less than the register number.
// - All measurement registers are read-only and filled by the measurement process, except the used-temperature ones while compensation is on.
// - By default the used-temperature float mirrors the probe temperature float.
// - With temperature compensation on, the used-temperature registers show the given temperature.
// - The 16-bit used-temperature register follows the same selection as the float one.
// - Integer relative saturation, humidity, both temperatures and dew point are scaled by 100.
// - Integer concentrations, absolute amounts and pressures are in base units, unscaled.
// - Floats sit at even addresses 0000 to 001A, integers at 0100 to 010D, gaps unmapped.
// - Each float has its low half at the listed address and its high half at the next.
// - Integers saturate to 7FFF and 8001 and read 8000 when unavailable.
`timescale 1ns/1ps
`include "probe_map.svh"
module probe_meas_regs #(
    parameter int NUM_QTY = `PM_NUM_QTY
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Measurement process
    input wire logic sample_i,
    input wire probe_pkg::float_bank_t meas_float_i,
    input wire probe_pkg::centi_bank_t meas_centi_i,
    input wire logic [NUM_QTY-1:0] meas_avail_i,
    // Temperature compensation source
    input wire logic temp_comp_on_i,
    input wire logic [31:0] given_temp_float_i,
    input wire logic signed [31:0] given_temp_centi_i,
    // Register request from the framer
    input wire logic txn_hold_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire probe_pkg::pdu_addr_t req_addr_i,
    // Register answer
    output logic rsp_valid_o,
    output probe_pkg::reg_word_t rsp_data_o,
    output logic rsp_exc_o,
    output logic temp_comp_active_o
);
    import probe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Map a PDU address to a quantity slot; the pair 000C/000D and 0106
    // are holes in the map and decode as misses
    function automatic addr_dec_t decode_addr(input pdu_addr_t a);
        addr_dec_t d;
        slot_t p;
        d = '0;
        p = '0;
        if (a <= `PM_FLOAT_LAST_ADDR) begin
            p = a[4:1];
            d.is_float = 1'b1;
            d.high_half = a[0];
            d.hit = (p != `PM_FLOAT_GAP_PAIR);
        end else if (a[15:4] == `PM_INT_PAGE && a[3:0] <= `PM_INT_LAST_LOW) begin
            p = a[3:0];
            d.hit = (p != `PM_INT_GAP_LOW);
        end
        d.slot = (p > `PM_FLOAT_GAP_PAIR) ? p - 4'h1 : p;
        return d;
    endfunction

    // Select the 16-bit word a decoded read returns
    function automatic reg_word_t pick_word(input addr_dec_t d, input bank_state_t s);
        reg_word_t w;
        logic [31:0] f;
        w = `PM_WORD_ZERO;
        f = s.flt[d.slot];
        if (d.is_float) begin
            w = d.high_half ? f[31:16] : f[15:0];
        end else begin
            w = s.fix[d.slot];
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Integer presentation of each quantity

    logic signed [NUM_QTY-1:0][31:0] centi_src;
    logic [NUM_QTY-1:0] avail_src;
    logic [NUM_QTY-1:0][15:0] int_code;
    logic [NUM_QTY-1:0] scaled_mask;
    logic [31:0] temp_used_float;

    assign scaled_mask = `PM_SCALED_MASK;

    // Temperature used for calculation: probe value unless compensation
    // is on, then the host-given volatile value
    assign temp_used_float = temp_comp_on_i ? given_temp_float_i
                                            : meas_float_i[`PM_SLOT_PROBE_TEMP];

    // Integer sources; the used-temperature slot follows the same switch
    always_comb begin
        centi_src = meas_centi_i;
        avail_src = meas_avail_i;
        if (temp_comp_on_i) begin
            centi_src[`PM_SLOT_TEMP_USED] = given_temp_centi_i;
            avail_src[`PM_SLOT_TEMP_USED] = 1'b1;
        end else begin
            centi_src[`PM_SLOT_TEMP_USED] = meas_centi_i[`PM_SLOT_PROBE_TEMP];
            avail_src[`PM_SLOT_TEMP_USED] = meas_avail_i[`PM_SLOT_PROBE_TEMP];
        end
    end

    // One presenter per quantity
    genvar gi;
    generate
        for (gi = 0; gi < NUM_QTY; gi++) begin : g_present
            int16_present u_present (
                .centi_i(centi_src[gi]),
                .avail_i(avail_src[gi]),
                .scaled_i(scaled_mask[gi]),
                .code_o(int_code[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // State update

    bank_state_t state;
    bank_state_t next_state;
    addr_dec_t dec;

    assign dec = decode_addr(req_addr_i);

    // Snapshot on sample unless a frame is open; answer each request
    always_comb begin
        next_state = state;
        next_state.phase = PH_IDLE;
        // A frame in progress freezes the snapshot so that both halves
        // of a float come from one sample
        if (sample_i && !txn_hold_i) begin
            next_state.flt = meas_float_i;
            next_state.flt[`PM_SLOT_TEMP_USED] = temp_used_float;
            next_state.fix = int_code;
            next_state.comp_on = temp_comp_on_i;
        end
        if (req_valid_i) begin
            next_state.phase = PH_ANSWER;
            if (req_write_i || !dec.hit) begin
                // Writes never reach the bank; holes are unmapped
                next_state.rsp_exc = 1'b1;
                next_state.rsp_data = `PM_WORD_ZERO;
            end else begin
                next_state.rsp_exc = 1'b0;
                next_state.rsp_data = pick_word(dec, state);
            end
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state.flt <= {NUM_QTY{`PM_FLOAT_RESET}};
            state.fix <= {NUM_QTY{`PM_INT_RESET}};
            state.phase <= PH_IDLE;
            state.rsp_exc <= 1'b0;
            state.rsp_data <= `PM_WORD_ZERO;
            state.comp_on <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Answer strobe and registered data
    always_comb begin
        case (state.phase)
            PH_ANSWER: rsp_valid_o = 1'b1;
            PH_IDLE: rsp_valid_o = 1'b0;
            default: rsp_valid_o = 1'b0;
        endcase
    end

    assign rsp_data_o = state.rsp_data;
    assign rsp_exc_o = state.rsp_exc;
    assign temp_comp_active_o = state.comp_on; // Source of the held snapshot
endmodule

// ---- test/probe_meas_regs_props.sv ----
/* Checker of the register port and snapshot of probe_meas_regs.
   Sees only the top ports; bound from the bench top. */
`timescale 1ns/1ps
module probe_meas_regs_props (
    // Clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic sample_i,
    input wire logic temp_comp_on_i,
    input wire logic txn_hold_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire probe_pkg::pdu_addr_t req_addr_i,
    // Answer
    input wire logic rsp_valid_o,
    input wire probe_pkg::reg_word_t rsp_data_o,
    input wire logic rsp_exc_o,
    input wire logic temp_comp_active_o
);
    import probe_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic rd;
    // Read request qualifier
    assign rd = req_valid_i && !req_write_i;
    property p_ans; req_valid_i |=> rsp_valid_o; endproperty
    a_ans: assert property (p_ans) else $error("answer missing");
    property p_quiet; !req_valid_i |=> !rsp_valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_hold; !req_valid_i |=> $stable({rsp_exc_o, rsp_data_o}); endproperty
    a_hold: assert property (p_hold) else $error("answer moved");
    property p_wr; req_valid_i && req_write_i |=> rsp_exc_o && rsp_data_o == 16'h0000;
    endproperty
    a_wr: assert property (p_wr) else $error("write accepted");
    property p_gap; rd && req_addr_i inside {16'h000C, 16'h000D, 16'h0106} |=> rsp_exc_o;
    endproperty
    a_gap: assert property (p_gap) else $error("gap mapped");
    property p_far; rd && req_addr_i > 16'h010D |=> rsp_exc_o; endproperty
    a_far: assert property (p_far) else $error("far address mapped");
    property p_mid; rd && req_addr_i inside {[16'h001C:16'h00FF]} |=> rsp_exc_o; endproperty
    a_mid: assert property (p_mid) else $error("mid address mapped");
    property p_flt; rd && req_addr_i <= 16'h001B && req_addr_i[15:1] != 15'h0006
        |=> !rsp_exc_o; endproperty
    a_flt: assert property (p_flt) else $error("float refused");
    property p_int; rd && req_addr_i inside {[16'h0100:16'h010D]} && req_addr_i != 16'h0106
        |=> !rsp_exc_o; endproperty
    a_int: assert property (p_int) else $error("int refused");
    property p_act; sample_i && !txn_hold_i |=> temp_comp_active_o == $past(temp_comp_on_i);
    endproperty
    a_act: assert property (p_act) else $error("switch not taken");
endmodule

// ---- test/host_model.sv ----
/* Host side of the register port: framed reads and writes.
   Assumes the bank answers one cycle after each request. */
`timescale 1ns/1ps
module host_model (
    // Clock and answer
    input wire logic ref_clk_i,
    input wire logic rsp_valid_i,
    input wire probe_pkg::reg_word_t rsp_data_i,
    input wire logic rsp_exc_i,
    // Request
    output logic txn_hold_o,
    output logic req_valid_o,
    output logic req_write_o,
    output probe_pkg::pdu_addr_t req_addr_o
);
    import probe_pkg::*;
    // Idle lines at time zero
    initial begin
        txn_hold_o = 1'b0;
        req_valid_o = 1'b0;
        req_write_o = 1'b0;
        req_addr_o = 16'h0000;
    end
    // One frame of n registers back to back, halves gathered low first
    task automatic xfer(input logic w, input pdu_addr_t a, input int n,
            output logic [31:0] d, output logic e);
        d = 32'h0000_0000;
        e = 1'b0;
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk_i);
            txn_hold_o <= (i < n);
            req_valid_o <= (i < n);
            req_write_o <= w;
            req_addr_o <= a + 16'(i);
            #1;
            if (i > 0) begin
                d[16 * (i - 1) +: 16] = rsp_data_i;
                e = (rsp_valid_i === 1'b1) ? (e | rsp_exc_i) : 1'bx;
            end
        end
    endtask
endmodule

// ---- test/probe_meas_regs_tb.sv ----
/* Self-checking bench of probe_meas_regs with a host model.
   Assumes the design package and header are compiled first. */
`timescale 1ns/1ps
module probe_meas_regs_tb;
    import probe_pkg::*;
    logic ref_clk_i, nrst_i, sample_i, temp_comp_on_i, txn_hold_i, req_valid_i, req_write_i;
    logic rsp_valid_o, rsp_exc_o, temp_comp_active_o, ncomp;
    float_bank_t meas_float_i, nf;
    centi_bank_t meas_centi_i, nc;
    logic [12:0] meas_avail_i, na;
    logic [31:0] given_temp_float_i, ngf;
    logic signed [31:0] given_temp_centi_i, ngc;
    pdu_addr_t req_addr_i;
    reg_word_t rsp_data_o;
    int n_errors, total_checks;
    probe_meas_regs i_dut (.ref_clk_i, .nrst_i, .sample_i, .meas_float_i, .meas_centi_i,
        .meas_avail_i, .temp_comp_on_i, .given_temp_float_i, .given_temp_centi_i,
        .txn_hold_i, .req_valid_i, .req_write_i, .req_addr_i, .rsp_valid_o, .rsp_data_o,
        .rsp_exc_o, .temp_comp_active_o);
    host_model i_host (.ref_clk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
        .rsp_exc_i(rsp_exc_o), .txn_hold_o(txn_hold_i), .req_valid_o(req_valid_i),
        .req_write_o(req_write_i), .req_addr_o(req_addr_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] icode(input int k, input logic signed [31:0] c);
        logic signed [31:0] v;
        v = (k inside {1, 2, 3, 5, 10}) ? c : c / 100;
        if (v >= 32767) return 16'h7FFF;
        if (v <= -32767) return 16'h8001;
        return v[15:0];
    endfunction
    // Applies the shadow values with a one-cycle sample pulse
    task automatic snap();
        @(posedge ref_clk_i);
        meas_float_i <= nf;
        meas_centi_i <= nc;
        meas_avail_i <= na;
        temp_comp_on_i <= ncomp;
        given_temp_float_i <= ngf;
        given_temp_centi_i <= ngc;
        sample_i <= 1'b1;
        @(posedge ref_clk_i);
        sample_i <= 1'b0;
    endtask
    // Reads every float and int slot against the shadow values
    task automatic check_all();
        logic [31:0] d, ef;
        logic e;
        logic signed [31:0] c;
        logic [15:0] ei;
        for (int k = 0; k < 13; k++) begin
            ef = (k == 2) ? (ncomp ? ngf : nf[10]) : nf[k];
            c = (k == 2) ? (ncomp ? ngc : nc[10]) : nc[k];
            ei = ((k == 2 && ncomp) || na[k == 2 ? 10 : k]) ? icode(k, c) : 16'h8000;
            i_host.xfer(1'b0, 16'(k < 6 ? 2 * k : 2 * k + 2), 2, d, e);
            chk({e, d}, {1'b0, ef});
            i_host.xfer(1'b0, 16'(k < 6 ? 256 + k : 257 + k), 1, d, e);
            chk({e, d}, {17'h0_0000, ei});
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        i_host.xfer(1'b0, 16'h0000, 2, d, e);
        chk({e, d}, 33'h0_7FC0_0000);
        i_host.xfer(1'b0, 16'h0100, 1, d, e);
        chk({e, d}, 33'h0_0000_8000);
        $display("reset values done");
    endtask
    task automatic t_map();
        for (int k = 0; k < 13; k++) begin
            nf[k] = 32'h4100_0000 + 32'(k);
            nc[k] = 1234 + 100 * k;
        end
        na = 13'h1FFF;
        snap();
        check_all();
        $display("map done");
    endtask
    task automatic t_comp();
        ncomp = 1'b1;
        snap();
        // Let the snapshot edge settle before looking
        #1;
        chk({32'h0, temp_comp_active_o}, 33'h0_0000_0001);
        check_all();
        ncomp = 1'b0;
        $display("compensation done");
    endtask
    task automatic t_sat();
        nc[0] = 3276600;
        nc[1] = -32767;
        nc[3] = 32767;
        nc[6] = -3276700;
        na[5] = 1'b0;
        snap();
        check_all();
        $display("saturation done");
    endtask
    // A sample offered while a frame is open is dropped, not deferred
    task automatic t_hold();
        logic [31:0] d, old;
        logic e;
        old = nf[12];
        nf[12] = 32'h4248_0000;
        fork
            i_host.xfer(1'b0, 16'h001A, 2, d, e);
            snap();
        join
        chk({e, d}, {1'b0, old});
        i_host.xfer(1'b0, 16'h001A, 2, d, e);
        chk({e, d}, {1'b0, old});
        snap();
        i_host.xfer(1'b0, 16'h001A, 2, d, e);
        chk({e, d}, {1'b0, nf[12]});
        $display("frame hold done");
    endtask
    task automatic t_err();
        logic [31:0] d;
        logic e;
        pdu_addr_t bad [6] = '{16'h000C, 16'h000D, 16'h001C, 16'h0106, 16'h010E, 16'h0302};
        foreach (bad[i]) begin
            i_host.xfer(1'b0, bad[i], 1, d, e);
            chk({e, d}, 33'h1_0000_0000);
        end
        i_host.xfer(1'b1, 16'h0004, 1, d, e);
        chk({e, d}, 33'h1_0000_0000);
        i_host.xfer(1'b0, 16'h0004, 2, d, e);
        chk({e, d}, {1'b0, nf[10]});
        $display("errors done");
    endtask
    // Clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Main sequence
    initial begin
        {nrst_i, sample_i, temp_comp_on_i, ncomp, na, meas_avail_i} = '0;
        {meas_float_i, nf, meas_centi_i, nc, given_temp_float_i} = '0;
        given_temp_centi_i = 32'sh0000_0000;
        ngf = 32'h41C8_0000;
        ngc = -2550;
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_map();
        t_comp();
        t_sat();
        t_hold();
        t_err();
        conclude();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_errors++;
        conclude();
    end
endmodule
bind probe_meas_regs probe_meas_regs_props i_props (.ref_clk_i, .nrst_i, .sample_i,
    .temp_comp_on_i, .txn_hold_i, .req_valid_i, .req_write_i, .req_addr_i, .rsp_valid_o,
    .rsp_data_o, .rsp_exc_o, .temp_comp_active_o);
